// ### verilog/gp_pkg.sv
// constants for the eight-bit general-purpose port: register map, reset values, bus codes
// assumes a 32-bit axi4-lite register bus with byte addresses on 8 bits
package gp_pkg;

  localparam int          GP_WIDTH      = 8;
  localparam int          GP_ADDR_W     = 8;
  localparam int          GP_TIMER_BIT  = 6;

  // register byte addresses
  localparam logic [7:0]  GP_ADDR_DIR   = 8'h00;
  localparam logic [7:0]  GP_ADDR_OUT   = 8'h04;
  localparam logic [7:0]  GP_ADDR_IN    = 8'h08;
  localparam logic [7:0]  GP_ADDR_ODR   = 8'h0C;
  localparam logic [7:0]  GP_ADDR_ALT   = 8'h10;
  localparam logic [7:0]  GP_ADDR_EDGE  = 8'h14;
  localparam logic [7:0]  GP_ADDR_MASK  = 8'h18;
  localparam logic [7:0]  GP_ADDR_STAT  = 8'h1C;
  localparam logic [7:0]  GP_ADDR_CTRL  = 8'h20;

  // control register fields
  localparam int          GP_CTRL_STOP  = 0;
  localparam int          GP_CTRL_T0SEL = 1;

  // reset values
  localparam logic [7:0]  GP_RST_DIR    = 8'h00;
  localparam logic [7:0]  GP_RST_OUT    = 8'hFF;
  localparam logic [7:0]  GP_RST_ODR    = 8'h00;
  localparam logic [7:0]  GP_RST_ALT    = 8'h0F;
  localparam logic [7:0]  GP_RST_EDGE   = 8'h00;
  localparam logic [7:0]  GP_RST_MASK   = 8'h00;
  localparam logic [7:0]  GP_RST_PIN    = 8'hFF;

  // axi response codes
  localparam logic [1:0]  GP_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  GP_RESP_SLVERR = 2'h2;

endpackage

// ### verilog/gp_sync.sv
// two-stage synchroniser, one pair of flip-flops per bit
// assumes the inputs may change at any time relative to clock
`timescale 1ns/10ps
module gp_sync
  import gp_pkg::*;
#(
  parameter int               W         = GP_WIDTH,
  parameter logic [W-1:0]     RST_VALUE = GP_RST_PIN
) (
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic [W-1:0]   async_in,
  output logic      [W-1:0]   sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gp_sync_s;

  gp_sync_s state;
  gp_sync_s next_state;

  // the first stage feeds only the second stage
  always_comb begin
    next_state = state;
    for (int i = 0; i < W; i++) begin
      next_state.stage1[i] = async_in[i];
      next_state.stage2[i] = state.stage1[i];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{stage1: RST_VALUE, stage2: RST_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule // gp_sync

// ### verilog/gp_port.sv
// eight-bit general-purpose port with alternate functions, edge interrupts and stop wake-up
// assumes an axi4-lite master on the register side and external pin pads with separate
// input, output, active-low output enable and pull-up control
//
// Function
// - one port of eight independently controllable bidirectional bits
// - every bit also carries an alternate function such as timer or debug
// - selected alternate function overrides direction, drive and pull-up of its pin
// - bit six may follow timer channel 0 output instead of the output latch
// - an input bit is either high impedance or weakly pulled up
// - after reset bits four to seven are inputs with their pull-ups on; bits zero to three follow the debug port
// - debug port owns its pins after reset; software releases them before port use
// - each bit raises an interrupt on a chosen rising or falling edge
// - in stop mode any enabled port interrupt wakes the device
// - stop mode ends on an enabled external interrupt or on external reset
// - direction register holds one bit per pin
// - writing the output register sets the level driven on output pins
// - reading the output register returns the stored latch for every bit
// - pin input register is read-only and returns every pin's level
// - for input pins the output register bit switches the pull-up
// - each output pin selects push-pull or open-drain drive
`timescale 1ns/10ps
module gp_port
  import gp_pkg::*;
#(
  parameter int W = GP_WIDTH
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // axi4-lite slave
  input  wire logic [GP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [GP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // pins of digital_port_zero
  input  wire logic [W-1:0]         pin_in,
  output logic      [W-1:0]         pin_out,
  output logic      [W-1:0]         pin_oe_n,
  output logic      [W-1:0]         pin_pullup,
  // alternate_function side
  input  wire logic [W-1:0]         alt_out,
  input  wire logic [W-1:0]         alt_drive,
  input  wire logic [W-1:0]         alt_pullup,
  output logic      [W-1:0]         alt_in,
  output logic      [W-1:0]         alt_select,
  input  wire logic                 timer0_out,
  // system
  output logic                      irq,
  output logic                      stop_mode,
  output logic                      wake
);

  typedef struct packed {
    logic [W-1:0]         dir;
    logic [W-1:0]         out_latch;
    logic [W-1:0]         odr;
    logic [W-1:0]         alt;
    logic [W-1:0]         edge_fall;
    logic [W-1:0]         mask;
    logic [W-1:0]         status;
    logic [W-1:0]         prev;
    logic                 t0_sel;
    logic                 stop;
    logic                 awready;
    logic                 wready;
    logic                 aw_full;
    logic                 w_full;
    logic [GP_ADDR_W-1:0] aw_addr;
    logic [W-1:0]         w_data;
    logic                 w_lane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [W-1:0]         pin_out;
    logic [W-1:0]         pin_oe_n;
    logic [W-1:0]         pin_pullup;
    logic                 irq;
    logic                 wake;
  } gp_port_s;

  gp_port_s     state;
  gp_port_s     next_state;
  logic [W-1:0] pin_sync;

  gp_sync #(
    .W         (W),
    .RST_VALUE (GP_RST_PIN)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // read decode; unmapped offsets answer with an error and zero data
  function automatic logic [33:0] read_word(input logic [GP_ADDR_W-1:0] addr,
                                            input gp_port_s s,
                                            input logic [W-1:0] pins);
    logic [GP_ADDR_W-1:0] a;
    logic [31:0]          d;
    logic [1:0]           r;
    a = {addr[GP_ADDR_W-1:2], 2'b00};
    d = '0;
    r = GP_RESP_OKAY;
    case (a)
      GP_ADDR_DIR:  d[W-1:0] = s.dir;
      GP_ADDR_OUT:  d[W-1:0] = s.out_latch;
      GP_ADDR_IN:   d[W-1:0] = pins;
      GP_ADDR_ODR:  d[W-1:0] = s.odr;
      GP_ADDR_ALT:  d[W-1:0] = s.alt;
      GP_ADDR_EDGE: d[W-1:0] = s.edge_fall;
      GP_ADDR_MASK: d[W-1:0] = s.mask;
      GP_ADDR_STAT: d[W-1:0] = s.status;
      GP_ADDR_CTRL: begin
        d[GP_CTRL_STOP]  = s.stop;
        d[GP_CTRL_T0SEL] = s.t0_sel;
      end
      default:      r = GP_RESP_SLVERR;
    endcase
    return {r, d};
  endfunction

  always_comb begin
    logic [W-1:0]         rise;
    logic [W-1:0]         fall;
    logic [W-1:0]         event_hit;
    logic [W-1:0]         clear;
    logic [W-1:0]         level;
    logic [GP_ADDR_W-1:0] wa;
    logic                 do_write;
    logic [33:0]          rd;
    logic [33:0]          wd;
    rise       = '0;
    fall       = '0;
    event_hit  = '0;
    clear      = '0;
    level      = '0;
    wa         = '0;
    do_write   = 1'b0;
    rd         = '0;
    wd         = '0;
    next_state = state;
    next_state.wake = 1'b0;

    // edge detection on synchronised pins only
    rise      = pin_sync & ~state.prev;
    fall      = ~pin_sync & state.prev;
    event_hit = (state.edge_fall & fall) | (~state.edge_fall & rise);
    next_state.prev = pin_sync;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_full  = 1'b1;
      next_state.w_data  = s_axi_wdata[W-1:0];
      next_state.w_lane0 = s_axi_wstrb[0];
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.aw_full && state.w_full && !state.bvalid) begin
      do_write            = state.w_lane0;
      wa                  = {state.aw_addr[GP_ADDR_W-1:2], 2'b00};
      next_state.aw_full  = 1'b0;
      next_state.w_full   = 1'b0;
      next_state.bvalid   = 1'b1;
      wd                  = read_word(state.aw_addr, state, pin_sync);
      next_state.bresp    = wd[33:32];
    end

    if (do_write) begin
      case (wa)
        GP_ADDR_DIR:  next_state.dir       = state.w_data;
        GP_ADDR_OUT:  next_state.out_latch = state.w_data;
        GP_ADDR_ODR:  next_state.odr       = state.w_data;
        GP_ADDR_ALT:  next_state.alt       = state.w_data;
        GP_ADDR_EDGE: next_state.edge_fall = state.w_data;
        GP_ADDR_MASK: next_state.mask      = state.w_data;
        GP_ADDR_STAT: clear                = state.w_data;
        GP_ADDR_CTRL: begin
          next_state.t0_sel = state.w_data[GP_CTRL_T0SEL];
          if (state.w_data[GP_CTRL_STOP]) begin
            next_state.stop = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // a new edge in the clearing cycle stays set
    next_state.status = (state.status & ~clear) | event_hit;

    // only the port's own edges or reset end stop mode
    if (state.stop && |(event_hit & state.mask)) begin
      next_state.stop = 1'b0;
      next_state.wake = 1'b1;
    end

    // read channel: answer in the cycle after the address is taken
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state.arready) begin
      rd                = read_word(s_axi_araddr, state, pin_sync);
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd[31:0];
      next_state.rresp  = rd[33:32];
    end

    next_state.awready = !next_state.aw_full && !next_state.bvalid;
    next_state.wready  = !next_state.w_full && !next_state.bvalid;
    next_state.arready = !next_state.rvalid;

    // pad control, registered so the pins never glitch on decode
    for (int i = 0; i < W; i++) begin
      level[i] = next_state.out_latch[i];
      if (i == GP_TIMER_BIT && next_state.t0_sel) begin
        level[i] = timer0_out;
      end
      if (next_state.alt[i]) begin
        next_state.pin_out[i]    = alt_out[i];
        next_state.pin_oe_n[i]   = !alt_drive[i];
        next_state.pin_pullup[i] = alt_pullup[i];
      end else if (next_state.dir[i]) begin
        next_state.pin_pullup[i] = 1'b0;
        if (next_state.odr[i]) begin
          next_state.pin_out[i]  = 1'b0;
          next_state.pin_oe_n[i] = level[i];
        end else begin
          next_state.pin_out[i]  = level[i];
          next_state.pin_oe_n[i] = 1'b0;
        end
      end else begin
        next_state.pin_out[i]    = 1'b0;
        next_state.pin_oe_n[i]   = 1'b1;
        next_state.pin_pullup[i] = next_state.out_latch[i];
      end
    end

    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state            <= '0;
      state.dir        <= GP_RST_DIR;
      state.out_latch  <= GP_RST_OUT;
      state.odr        <= GP_RST_ODR;
      state.alt        <= GP_RST_ALT;
      state.edge_fall  <= GP_RST_EDGE;
      state.mask       <= GP_RST_MASK;
      state.prev       <= GP_RST_PIN;
      state.awready    <= 1'b1;
      state.wready     <= 1'b1;
      state.arready    <= 1'b1;
      state.pin_oe_n   <= '1;
      state.pin_pullup <= GP_RST_OUT;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign pin_out       = state.pin_out;
  assign pin_oe_n      = state.pin_oe_n;
  assign pin_pullup    = state.pin_pullup;
  assign alt_in        = pin_sync;
  assign alt_select    = state.alt;
  assign irq           = state.irq;
  assign stop_mode     = state.stop;
  assign wake          = state.wake;

endmodule // gp_port

// ### sim/gp_port_props.sv
// assertion checker for the general-purpose port, bound to gp_port
// assumes one clock domain and the active-low asynchronous reset of the top module
`timescale 1ns/10ps
module gp_port_props
  import gp_pkg::*;
#(
  parameter int W = GP_WIDTH
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         s_axi_arvalid,
  input  wire logic         s_axi_arready,
  input  wire logic         s_axi_rvalid,
  input  wire logic         s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [1:0]   s_axi_bresp,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] pin_pullup,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_drive,
  input  wire logic [W-1:0] alt_in,
  input  wire logic [W-1:0] alt_select,
  input  wire logic         irq,
  input  wire logic         stop_mode,
  input  wire logic         wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing one cycle after address");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");
  AST_PP_NO_PU: assert property (((~pin_oe_n) & pin_pullup & (~alt_select)) == '0)
    else $error("pull-up on while port drives pin");
  // first edge after release still shows reset pads, hence the past guard
  AST_ALT_OUT: assert property ($past(rst_n) |-> ((pin_out ^ $past(alt_out)) & alt_select) == '0)
    else $error("alternate output not on pin");
  AST_ALT_OE: assert property ($past(rst_n) |-> ((pin_oe_n ^ ~$past(alt_drive)) & alt_select) == '0)
    else $error("alternate drive not on pin enable");
  AST_SYNC: assert property ($past(rst_n) && $past(rst_n, 2) |-> alt_in == $past(pin_in, 2))
    else $error("pin level not two stages late");
  AST_STOP_END: assert property ($fell(stop_mode) |-> wake && irq)
    else $error("stop left without enabled interrupt");
  AST_WAKE_ONE: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt dropped without register write");
endmodule // gp_port_props

bind gp_port gp_port_props #(.W(W)) i_gp_port_props (
  .clock(clock), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
  .alt_out(alt_out), .alt_drive(alt_drive), .alt_in(alt_in), .alt_select(alt_select), .irq(irq),
  .stop_mode(stop_mode), .wake(wake)
);

// ### sim/gp_pins_model.sv
// outside world of the port pins: device drive wins, then an outside driver, then the pull-up
// assumes the bench sets ext_en and ext_val by non-blocking assignment at the clock edge
`timescale 1ns/10ps
module gp_pins_model
  import gp_pkg::*;
(
  input  wire logic                clock,
  input  wire logic [GP_WIDTH-1:0] pin_out,
  input  wire logic [GP_WIDTH-1:0] pin_oe_n,
  input  wire logic [GP_WIDTH-1:0] pin_pullup,
  input  wire logic [GP_WIDTH-1:0] ext_en,
  input  wire logic [GP_WIDTH-1:0] ext_val,
  output logic      [GP_WIDTH-1:0] pin_level
);
  logic [GP_WIDTH-1:0] float_pat = 8'hA5;

  // an undriven pad without pull-up never settles to a usable level
  always @(posedge clock) float_pat <= ~float_pat;

  always_comb begin
    for (int i = 0; i < GP_WIDTH; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pin_pullup[i]) pin_level[i] = 1'b1;
      else pin_level[i] = float_pat[i];
    end
  end
endmodule // gp_pins_model

// ### sim/gp_port_bench.sv
// self-checking bench for gp_port: axi4-lite register tasks, pin model, random and corner tests
// assumes the bound checker and gp_pins_model are compiled with the design
`timescale 1ns/10ps
module gp_port_bench;
  import gp_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, timer0_out = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, stop_mode, wake;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  // debug pins idle pulled high after reset, so no stray edges reach the status register
  logic [7:0]  alt_out = 8'h00, alt_drive = 8'h00, alt_pullup = 8'hFF;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup, alt_in, alt_select;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  int          err_total = 0, total_checks = 0, cyc = 0, wake_cnt = 0;
  logic [15:0] rst_tab [7] = '{{GP_ADDR_DIR, GP_RST_DIR}, {GP_ADDR_OUT, GP_RST_OUT}, {GP_ADDR_ODR, GP_RST_ODR},
    {GP_ADDR_ALT, GP_RST_ALT}, {GP_ADDR_EDGE, GP_RST_EDGE}, {GP_ADDR_MASK, GP_RST_MASK}, {GP_ADDR_STAT, 8'h00}};

  gp_port i_gp_port (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .alt_out(alt_out), .alt_drive(alt_drive), .alt_pullup(alt_pullup), .alt_in(alt_in),
    .alt_select(alt_select), .timer0_out(timer0_out), .irq(irq), .stop_mode(stop_mode), .wake(wake));
  gp_pins_model i_gp_pins_model (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  initial forever #12.5 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (wake === 1'b1) wake_cnt++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic late;
    // a late bready now and then keeps the response waiting on the bus
    late = 1'($urandom);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er, input logic [7:0] m);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk($sformatf("rdata at %h", a), rdata & {24'hFFFFFF, m}, {24'h0, e & m});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  initial begin
    logic [7:0] d, o, od, en, v, drv, x, m;
    logic       e;
    int         i, n;
    void'($urandom(32'hE462));
    repeat (16) @(posedge clock);
    chk("reset pads", {pin_oe_n, pin_pullup}, 16'hFFFF);
    rst_n <= 1'b1;
    foreach (rst_tab[k]) rd(rst_tab[k][15:8], rst_tab[k][7:0], GP_RESP_OKAY, 8'hFF);
    rd(8'h24, 8'h00, GP_RESP_SLVERR, 8'hFF);
    wr(8'h24, 32'h0, GP_RESP_SLVERR);
    wr(GP_ADDR_IN, 32'h0, GP_RESP_OKAY);
    wr(GP_ADDR_ALT, 32'h0, GP_RESP_OKAY);
    $display("test reset and map done");
    repeat (24) begin
      d = 8'($urandom);
      o = 8'($urandom);
      od = 8'($urandom);
      en = 8'($urandom);
      v = 8'($urandom);
      ext_en <= en;
      ext_val <= v;
      wr(GP_ADDR_DIR, {24'h0, d}, GP_RESP_OKAY);
      wr(GP_ADDR_OUT, {24'h0, o}, GP_RESP_OKAY);
      wr(GP_ADDR_ODR, {24'h0, od}, GP_RESP_OKAY);
      repeat (4) @(posedge clock);
      chk("pads", {8'h0, pin_oe_n, pin_out, pin_pullup}, {8'h0, ~d | (od & o), d & ~od & o, ~d & o});
      rd(GP_ADDR_OUT, o, GP_RESP_OKAY, 8'hFF);
      drv = d & ~(od & o);
      x = (d & ~od & o) | (~drv & ((en & v) | ~en));
      m = drv | en | (~d & o);
      rd(GP_ADDR_IN, x, GP_RESP_OKAY, m);
    end
    $display("test random port setup done");
    wr(GP_ADDR_CTRL, 32'h2, GP_RESP_OKAY);
    wr(GP_ADDR_DIR, 32'h40, GP_RESP_OKAY);
    wr(GP_ADDR_ODR, 32'h0, GP_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      timer0_out <= i[0];
      repeat (3) @(posedge clock);
      chk("timer bit", {31'h0, pin_out[GP_TIMER_BIT]}, {31'h0, i[0]});
    end
    wr(GP_ADDR_CTRL, 32'h0, GP_RESP_OKAY);
    wr(GP_ADDR_ALT, 32'hFF, GP_RESP_OKAY);
    alt_out <= 8'($urandom);
    alt_drive <= 8'($urandom);
    alt_pullup <= 8'($urandom);
    repeat (3) @(posedge clock);
    chk("alt pads", {pin_out, pin_oe_n, pin_pullup, alt_select}, {alt_out, ~alt_drive, alt_pullup, 8'hFF});
    wr(GP_ADDR_ALT, 32'h0, GP_RESP_OKAY);
    wr(GP_ADDR_DIR, 32'h0, GP_RESP_OKAY);
    $display("test timer and alternate done");
    ext_en <= 8'hFF;
    for (int b = 0; b < 16; b++) begin
      e = b[3];
      i = b % 8;
      ext_val <= {8{e}};
      wr(GP_ADDR_EDGE, {24'h0, {8{e}}}, GP_RESP_OKAY);
      wr(GP_ADDR_MASK, ~(32'h1 << i) & 32'hFF, GP_RESP_OKAY);
      wr(GP_ADDR_STAT, 32'hFF, GP_RESP_OKAY);
      wr(GP_ADDR_CTRL, 32'h1, GP_RESP_OKAY);
      ext_val[i] <= ~e;
      repeat (5) @(posedge clock);
      chk("masked edge", {30'h0, irq, stop_mode}, 32'h1);
      rd(GP_ADDR_STAT, 8'h1 << i, GP_RESP_OKAY, 8'hFF);
      wr(GP_ADDR_MASK, 32'h1 << i, GP_RESP_OKAY);
      repeat (3) @(posedge clock);
      chk("unmasked", {30'h0, irq, stop_mode}, 32'h3);
      wr(GP_ADDR_STAT, 32'h1 << i, GP_RESP_OKAY);
      ext_val[i] <= e;
      repeat (5) @(posedge clock);
      chk("cleared", {30'h0, irq, stop_mode}, 32'h1);
      n = wake_cnt;
      ext_val[i] <= ~e;
      repeat (5) @(posedge clock);
      chk("wake", {29'h0, wake_cnt == n + 1, irq, stop_mode}, 32'h6);
    end
    $display("test edges and stop done");
    wr(GP_ADDR_CTRL, 32'h1, GP_RESP_OKAY);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    chk("reset ends stop", {23'h0, stop_mode, pin_pullup}, 32'hFF);
    rst_n <= 1'b1;
    rd(GP_ADDR_DIR, GP_RST_DIR, GP_RESP_OKAY, 8'hFF);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // gp_port_bench
